// ---- design/dipf_pkg.sv ----
// shared constants and types for the dac input port formatter
package dipf_pkg;
  localparam int DW = 14;
  localparam int FIFO_DEPTH = 8;
  localparam logic [DW-1:0] MID_CODE = 14'h2000;
  localparam int CLK_HZ = 20_000_000;
  localparam int CONV_MAX_MHZ = 2400;
  localparam int PORT_MAX_MSPS = 1200;
  localparam int CLK_DIV = 4;
  localparam int LOCK_PERIODS = 8;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DLL = 8'h08;
  localparam logic [7:0] OFS_SAMPLE = 8'h0c;
  localparam logic [7:0] OFS_LEVEL = 8'h10;
  // control fields
  localparam int CTRL_OUT_EN = 0;
  localparam int CTRL_CLR = 1;
  localparam logic CTRL_OUT_EN_RST = 1'b1;
  // status fields
  localparam int ST_MODE = 0;
  localparam int ST_VALID = 2;
  localparam int ST_MODE_ERR = 3;
  localparam int ST_OVF = 4;
  localparam int ST_LOCK = 5;
  typedef enum logic [1:0] {
    DIPF_INTERLEAVE = 2'b00,
    DIPF_REPEAT = 2'b01,
    DIPF_INVERT = 2'b10,
    DIPF_ZERO_STUFF = 2'b11
  } dipf_mode_t;
endpackage

// ---- design/dipf_top.sv ----
// two-port dac input formatter: capture, dll, fifo, merge, wishbone regs
// What this block does
// - exactly one of four mode pins chooses format
// - interleave mode emits A then B alternately
// - repeat mode emits each A sample twice
// - invert mode emits A then its negation
// - zero-stuff mode emits A then zero
// - converter at most 2400 MHz, ports 1.2 GSPS
// - source clock is converter clock divided by four
// - dll aligns data latch to reference bit
// - dll tracks drift continuously without software
// - straight binary code, bit 13 is msb
// - logical bit is the positive differential line
// - all ones steers full scale to positive output
// - output currents proportional to code and complement
// - decoded code drives complementary switch controls
`timescale 1ns/1ns
module dipf_fifo #(
  parameter int W = 28,
  parameter int D = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o,
  output logic [$clog2(D):0] level_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wp;
  logic [AW:0] rp;
  logic push;
  logic pop;
  assign level_o = wp - rp;
  assign in_ready_o = level_o != D[AW:0];
  assign out_valid_o = wp != rp;
  assign out_data_o = mem[rp[AW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp[AW-1:0]] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (push) begin
        wp <= wp + 1'b1;
      end
      if (pop) begin
        rp <= rp + 1'b1;
      end
    end
  end
endmodule // dipf_fifo

`timescale 1ns/1ns
module dipf_top #(
  parameter int DEPTH = dipf_pkg::FIFO_DEPTH,
  parameter int LOCK_N = dipf_pkg::LOCK_PERIODS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // mode select pins
  input wire logic interleave_sel_i,
  input wire logic single_port_repeat_sel_i,
  input wire logic single_port_invert_sel_i,
  input wire logic single_port_zero_stuff_sel_i,
  // data ports, positive lines
  input wire logic [dipf_pkg::DW-1:0] even_port_data_i,
  input wire logic [dipf_pkg::DW-1:0] odd_port_data_i,
  input wire logic reference_bit_in_i,
  // clock to the data source
  output logic source_clock_out_p_o,
  output logic source_clock_out_n_o,
  // current switch controls
  output logic [dipf_pkg::DW-1:0] sw_p_o,
  output logic [dipf_pkg::DW-1:0] sw_n_o,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import dipf_pkg::*;

  localparam int PW = 4 + 1 + 2 * DW;
  localparam bit RATE_OK = (CLK_HZ / 1_000_000) <= CONV_MAX_MHZ
    && (CLK_HZ / 2 / 1_000_000) <= PORT_MAX_MSPS;

  // three-stage pin capture; a bit changes once stages two and three agree
  logic [PW-1:0] s1;
  logic [PW-1:0] s2;
  logic [PW-1:0] s3;
  logic [PW-1:0] pins;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      pins <= '0;
    end else begin
      s1 <= {interleave_sel_i, single_port_repeat_sel_i, single_port_invert_sel_i,
             single_port_zero_stuff_sel_i, reference_bit_in_i,
             even_port_data_i, odd_port_data_i};
      s2 <= s1;
      s3 <= s2;
      pins <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & pins);
    end
  end
  logic [3:0] sel_pins;
  logic ref_bit;
  logic [DW-1:0] a_in;
  logic [DW-1:0] b_in;
  assign {sel_pins, ref_bit, a_in, b_in} = pins;

  // mode decode
  dipf_mode_t mode;
  logic mode_valid;
  logic one_hot;
  assign one_hot = $onehot(sel_pins);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= DIPF_INTERLEAVE;
      mode_valid <= 1'b0;
    end else begin
      mode_valid <= one_hot;
      // a pattern that is not one-hot keeps the last mode; the output is muted anyway
      if (one_hot) begin
        unique case (1'b1)
          sel_pins[3]: mode <= DIPF_INTERLEAVE;
          sel_pins[2]: mode <= DIPF_REPEAT;
          sel_pins[1]: mode <= DIPF_INVERT;
          sel_pins[0]: mode <= DIPF_ZERO_STUFF;
        endcase
      end
    end
  end

  // divide by four for the source clock
  logic [1:0] dcnt;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dcnt <= '0;
      source_clock_out_p_o <= 1'b0;
      source_clock_out_n_o <= 1'b1;
    end else begin
      dcnt <= dcnt + 1'b1;
      if (dcnt[0]) begin
        source_clock_out_p_o <= ~source_clock_out_p_o;
        source_clock_out_n_o <= source_clock_out_p_o;
      end
    end
  end

  // dll: find the reference transition phase, steer the latch one step per period
  logic ref_d;
  logic seen;
  logic [1:0] edge_ph;
  logic [1:0] tap;
  logic [1:0] diff;
  logic [3:0] lock_cnt;
  logic locked;
  assign diff = edge_ph + 2'd1 - tap;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_d <= 1'b0;
      seen <= 1'b0;
      edge_ph <= '0;
    end else begin
      ref_d <= ref_bit;
      if (ref_bit != ref_d) begin
        edge_ph <= dcnt;
        seen <= 1'b1;
      end else if (dcnt == 2'd3) begin
        seen <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tap <= '0;
      lock_cnt <= '0;
      locked <= 1'b0;
    end else if (dcnt == 2'd3 && seen) begin
      // single steps keep the latch point from jumping across a word
      if (diff == 2'd3) begin
        tap <= tap - 1'b1;
      end else if (diff != 2'd0) begin
        tap <= tap + 1'b1;
      end
      if (diff == 2'd0) begin
        if (lock_cnt != LOCK_N[3:0]) begin
          lock_cnt <= lock_cnt + 1'b1;
        end
      end else begin
        lock_cnt <= '0;
      end
      locked <= diff == 2'd0 && lock_cnt == LOCK_N[3:0];
    end
  end

  // capture one word per port on each source-clock edge
  logic cap;
  logic f_in_ready;
  logic f_out_valid;
  logic f_out_ready;
  logic [2*DW-1:0] f_out;
  logic [$clog2(DEPTH):0] level;
  logic ovf_set;
  assign cap = dcnt[0] == tap[0];
  assign ovf_set = cap && !f_in_ready;
  dipf_fifo #(.W(2 * DW), .D(DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(cap),
    .in_ready_o(f_in_ready),
    .in_data_i({a_in, b_in}),
    .out_valid_o(f_out_valid),
    .out_ready_i(f_out_ready),
    .out_data_o(f_out),
    .level_o(level)
  );

  // merge stage: two samples per word, one per clock
  logic out_en;
  logic hv;
  logic slot;
  logic [2*DW-1:0] word;
  logic [DW-1:0] code;
  logic [DW-1:0] first_s;
  logic [DW-1:0] second_s;
  assign f_out_ready = out_en && (!hv || slot);
  assign first_s = word[2*DW-1:DW];
  always_comb begin
    unique case (mode)
      DIPF_INTERLEAVE: second_s = word[DW-1:0];
      DIPF_REPEAT: second_s = first_s;
      DIPF_INVERT: second_s = ~first_s;
      DIPF_ZERO_STUFF: second_s = MID_CODE;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hv <= 1'b0;
      slot <= 1'b0;
      word <= '0;
    end else if (f_out_ready) begin
      hv <= f_out_valid;
      slot <= 1'b0;
      word <= f_out;
    end else if (hv && out_en) begin
      slot <= 1'b1;
    end
  end
  // mute to midscale while stalled or while the mode pins are not one-hot
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      code <= MID_CODE;
    end else if (hv && out_en && mode_valid) begin
      code <= slot ? second_s : first_s;
    end else begin
      code <= MID_CODE;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_p_o <= ~MID_CODE;
      sw_n_o <= MID_CODE;
    end else begin
      sw_p_o <= code;
      sw_n_o <= ~code;
    end
  end

  // wishbone slave, answers one cycle after the request
  logic req;
  logic wr_ctrl;
  logic mode_err;
  logic ovf;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // the write lands at the edge where the master sees ack, with the request still held
  assign wr_ctrl = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_adr_i == OFS_CTRL
    && wb_sel_i[0];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_en <= CTRL_OUT_EN_RST;
    end else if (wr_ctrl) begin
      out_en <= wb_dat_i[CTRL_OUT_EN];
    end
  end
  // set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_err <= 1'b0;
      ovf <= 1'b0;
    end else begin
      if (!one_hot) begin
        mode_err <= 1'b1;
      end else if (wr_ctrl && wb_dat_i[CTRL_CLR]) begin
        mode_err <= 1'b0;
      end
      if (ovf_set) begin
        ovf <= 1'b1;
      end else if (wr_ctrl && wb_dat_i[CTRL_CLR]) begin
        ovf <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        OFS_CTRL: wb_dat_o <= {31'h0, out_en};
        OFS_STATUS: wb_dat_o <= {26'h0, locked, ovf, mode_err, mode_valid, mode};
        OFS_DLL: wb_dat_o <= {28'h0, edge_ph, tap};
        OFS_SAMPLE: wb_dat_o <= {18'h0, code};
        OFS_LEVEL: wb_dat_o <= {{(31 - $clog2(DEPTH)){1'b0}}, level};
        default: wb_dat_o <= '0;
      endcase
    end else begin
      wb_dat_o <= '0;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence emit_first_s;
    hv && out_en && mode_valid && !slot && !f_out_ready;
  endsequence
  sequence emit_second_s;
    hv && out_en && mode_valid && slot;
  endsequence

  rate_limit_a: assert property (RATE_OK) else $error("clock over limit");
  mode_check_a: assert property (!rst_i && !one_hot |=> mode_err)
    else $error("mode error not flagged");
  interleave_out_a: assert property ((emit_second_s and (mode == DIPF_INTERLEAVE))
    |=> code == $past(word[DW-1:0])) else $error("interleave slot wrong");
  repeat_out_a: assert property (emit_first_s ##1 (emit_second_s and (mode == DIPF_REPEAT))
    |=> code == $past(code)) else $error("repeat not repeated");
  invert_out_a: assert property (emit_first_s ##1 (emit_second_s and (mode == DIPF_INVERT))
    |=> code == ~$past(code)) else $error("invert not inverted");
  zero_out_a: assert property ((emit_second_s and (mode == DIPF_ZERO_STUFF))
    |=> code == MID_CODE) else $error("zero slot wrong");
  src_div_a: assert property ($rose(source_clock_out_p_o)
    |-> ##2 $fell(source_clock_out_p_o) ##2 $rose(source_clock_out_p_o))
    else $error("source clock not divide by four");
  switch_pair_a: assert property (!rst_i |=> sw_n_o == ~sw_p_o && sw_p_o == $past(code))
    else $error("switch pair wrong");
  tap_step_a: assert property (##1 (tap == $past(tap) || tap == $past(tap) + 2'd1
    || tap == $past(tap) - 2'd1)) else $error("dll jumped");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
endmodule // dipf_top

// ---- tb/dipf_source.sv ----
// data source model: words on both divided-clock edges plus reference bit
`timescale 1ns/1ns
module dipf_source (
  // divided clock from the device
  input wire logic src_clk_i,
  // words to send, straight binary
  input wire logic [dipf_pkg::DW-1:0] a_i,
  input wire logic [dipf_pkg::DW-1:0] b_i,
  // port pins
  output logic [dipf_pkg::DW-1:0] even_o,
  output logic [dipf_pkg::DW-1:0] odd_o,
  output logic ref_o
);
  initial begin
    even_o = 14'h0;
    odd_o = 14'h0;
    ref_o = 1'b0;
  end
  // a word per port on every edge; each word thus holds two device clocks
  always @(src_clk_i) begin
    even_o <= a_i;
    odd_o <= b_i;
    ref_o <= ~ref_o;
  end
endmodule // dipf_source

// ---- tb/testbench.sv ----
// self-checking bench for the dac input port formatter
`timescale 1ns/1ns
module testbench;
  import dipf_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] pins = 4'h1;
  logic [DW-1:0] a = 14'h1234;
  logic [DW-1:0] b = 14'h0abc;
  logic [DW-1:0] even, odd, sw_p, sw_n;
  logic refb, scp, scn, ack;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, q;
  int errors = 0;
  int checked = 0;
  always #25 clk_i = ~clk_i;
  dipf_source src (.src_clk_i(scp), .a_i(a), .b_i(b), .even_o(even), .odd_o(odd),
    .ref_o(refb));
  dipf_top #(.LOCK_N(2)) dut (.clk_i(clk_i), .rst_i(rst_i), .interleave_sel_i(pins[0]),
    .single_port_repeat_sel_i(pins[1]), .single_port_invert_sel_i(pins[2]),
    .single_port_zero_stuff_sel_i(pins[3]), .even_port_data_i(even),
    .odd_port_data_i(odd), .reference_bit_in_i(refb), .source_clock_out_p_o(scp),
    .source_clock_out_n_o(scn), .sw_p_o(sw_p), .sw_n_o(sw_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack));
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // classic cycle: hold everything until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
    if (n >= 50) begin
      errors++;
      summarize();
    end
  endtask
  task automatic reset_check;
    check(32'(sw_p), 32'h1fff);
    check(32'(sw_n), 32'h2000);
    check(32'({scp, scn}), 32'h1);
    wb(1'b0, OFS_CTRL, 32'h0);
    check(q, 32'h1);
    wb(1'b0, 8'h14, 32'h0);
    check(q, 32'h0);
  endtask
  // waits past the pin pipeline, then finds a first-slot sample and its partner
  task automatic run_mode(input logic [3:0] p, input logic [1:0] code,
      input logic [DW-1:0] av, input logic [DW-1:0] bv, input logic [DW-1:0] second);
    int n;
    pins <= p;
    a <= av;
    b <= bv;
    repeat (24) @(posedge clk_i);
    wb(1'b0, OFS_STATUS, 32'h0);
    check(32'(q[2:0]), 32'({1'b1, code}));
    n = 0;
    while (sw_p !== av && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20) begin
      errors++;
      summarize();
    end
    @(posedge clk_i);
    check(32'(sw_p), 32'(second));
    check(32'(sw_n), 32'(second ^ 14'h3fff));
    @(posedge clk_i);
    check(32'(sw_p), 32'(av));
  endtask
  task automatic clock_check;
    logic s;
    @(posedge clk_i);
    s = scp;
    check(32'(scn), 32'(!s));
    repeat (2) @(posedge clk_i);
    check(32'(scp), 32'(!s));
    repeat (2) @(posedge clk_i);
    check(32'(scp), 32'(s));
    wb(1'b0, OFS_STATUS, 32'h0);
    check(32'(q[5]), 32'h1);
  endtask
  // clear first so that the error flag must come from the bad pattern itself
  task automatic error_check;
    wb(1'b1, OFS_CTRL, 32'h3);
    pins <= 4'h3;
    repeat (24) @(posedge clk_i);
    wb(1'b0, OFS_STATUS, 32'h0);
    check(32'(q[3:2]), 32'h2);
    pins <= 4'h1;
    repeat (24) @(posedge clk_i);
    wb(1'b1, OFS_CTRL, 32'h3);
    wb(1'b0, OFS_STATUS, 32'h0);
    check(32'(q[3:2]), 32'h1);
  endtask
  // drain stalled: fifo fills and refuses, then output resumes
  task automatic stall_check;
    wb(1'b1, OFS_CTRL, 32'h0);
    repeat (40) @(posedge clk_i);
    wb(1'b0, OFS_LEVEL, 32'h0);
    check(q, 32'(FIFO_DEPTH));
    wb(1'b0, OFS_STATUS, 32'h0);
    check(32'(q[4]), 32'h1);
    wb(1'b1, OFS_CTRL, 32'h1);
    run_mode(4'h1, 2'h0, 14'h0f0f, 14'h3000, 14'h3000);
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    reset_check;
    run_mode(4'h1, 2'h0, 14'h1234, 14'h0abc, 14'h0abc);
    run_mode(4'h2, 2'h1, 14'h3fff, 14'h0abc, 14'h3fff);
    run_mode(4'h4, 2'h2, 14'h0001, 14'h0abc, 14'h3ffe);
    run_mode(4'h8, 2'h3, 14'h2abc, 14'h0abc, MID_CODE);
    clock_check;
    error_check;
    stall_check;
    summarize;
  end
endmodule // testbench
